// ---- dsz_pkg.sv ----
// Package of constants and carrier types for the decrement-skip-on-zero executor.
package dsz_pkg;
    // =========================================================================
    // Opcode layout
    // =========================================================================
    localparam logic [5:0] DSZ_OPC = 6'h0b;       // Upper six opcode bits 0010 11.
    localparam int DSZ_OPC_HI = 15;
    localparam int DSZ_OPC_LO = 10;
    localparam int DSZ_DEST_BIT = 9;
    localparam int DSZ_BANK_BIT = 8;
    localparam logic [7:0] DSZ_IDX_MAX = 8'h5f;   // Highest indexed literal offset.
    localparam logic [7:0] DSZ_ACC_SPLIT = 8'h60; // Access bank low/high split.
    localparam logic [3:0] DSZ_ACC_HI_BANK = 4'hf;
    localparam logic [1:0] DSZ_MAX_FLUSH = 2'h3;  // Up to three-word skipped opcode.
    localparam logic [7:0] DSZ_ONE = 8'h01;
    localparam logic [7:0] DSZ_ZERO = 8'h00;

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [1:0] {DSZ_Q1, DSZ_Q2, DSZ_Q3, DSZ_Q4} dsz_phase_t;

    // File register access request.
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
        logic indexed;
    } dsz_file_req_t;

    // Working register write.
    typedef struct packed {
        logic [7:0] data;
        logic wr;
    } dsz_wreg_t;
endpackage : dsz_pkg

// ---- dsz_decode.sv ----
// Opcode decoder and address former for the decrement-skip-on-zero executor.
`timescale 1ns/10ps
`default_nettype none
module dsz_decode (
    input wire logic [15:0] opcode_i,      // Fetched instruction word.
    input wire logic [3:0] bank_ptr_i,     // Bank pointer register.
    input wire logic ext_set_i,            // Extended instruction set enabled.
    input wire logic [7:0] fsr2_base_i,    // Index base for literal offset mode.
    output logic hit_o,                    // Opcode is decrement-skip-on-zero.
    output logic dest_file_o,              // Result goes back to the file.
    output logic indexed_o,                // Indexed literal offset in use.
    output logic [11:0] addr_o             // Full file register address.
);
    import dsz_pkg::*;
    logic [7:0] f_s;
    logic bank_s;

    // =========================================================================
    // Field decode and bank selection.
    // =========================================================================
    always_comb begin
        f_s = opcode_i[7:0];
        bank_s = opcode_i[DSZ_BANK_BIT];
        hit_o = (opcode_i[DSZ_OPC_HI:DSZ_OPC_LO] == DSZ_OPC);
        dest_file_o = opcode_i[DSZ_DEST_BIT];
        indexed_o = !bank_s && ext_set_i && (f_s <= DSZ_IDX_MAX);
        if (indexed_o) begin
            addr_o = {4'h0, 8'(fsr2_base_i + f_s)};
        end else if (bank_s) begin
            addr_o = {bank_ptr_i, f_s};
        end else if (f_s < DSZ_ACC_SPLIT) begin
            addr_o = {4'h0, f_s};
        end else begin
            addr_o = {DSZ_ACC_HI_BANK, f_s};
        end
    end
endmodule : dsz_decode
`default_nettype wire

// ---- dsz_exec.sv ----
// Execution unit for the decrement-skip-on-zero instruction.
// Contract
// - Decode 0010 11da opcode; flags stay untouched.
// - Destination bit picks working or file register.
// - Zero result flushes already fetched next instruction.
// - Bank bit picks access bank or bank pointer.
// - Indexed offset when bank zero, extended, f<=95.
// - One cycle, two on skip, more per word.
`timescale 1ns/10ps
`default_nettype none
module dsz_exec (
    input wire logic clk_i,                       // 50 MHz phase clock.
    input wire logic rst_i,                       // Synchronous reset, active high.
    input wire logic [15:0] opcode_i,             // Instruction held for this cycle.
    input wire logic [1:0] next_words_i,          // Word count of the following opcode.
    input wire logic [3:0] bank_ptr_i,            // Bank pointer register.
    input wire logic ext_set_i,                   // Extended instruction set enabled.
    input wire logic [7:0] fsr2_base_i,           // Index base for literal offsets.
    input wire logic [7:0] file_rdata_i,          // File data read in phase two.
    output dsz_pkg::dsz_phase_t phase_o,          // Current phase.
    output dsz_pkg::dsz_file_req_t file_o,        // File register request.
    output dsz_pkg::dsz_wreg_t wreg_o,            // Working register write.
    output logic busy_o,                          // Executing or flushing.
    output logic flush_o,                         // Current cycle is a no-operation.
    output logic fetch_adv_o                      // Advance to next instruction at Q4.
);
    import dsz_pkg::*;

    logic hit_s, dest_s, idx_s;
    logic [11:0] addr_s;
    dsz_phase_t phase_q, phase_d;
    logic [1:0] flush_q, flush_d;
    logic act_q, act_d;
    logic dest_q, dest_d, idx_q, idx_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] rd_q, rd_d, res_q, res_d;
    logic [1:0] nw_q, nw_d;
    dsz_file_req_t file_q, file_d;
    dsz_wreg_t wreg_q, wreg_d;

    // =========================================================================
    // Decoder instance.
    // =========================================================================
    dsz_decode u_dec (
        .opcode_i(opcode_i),
        .bank_ptr_i(bank_ptr_i),
        .ext_set_i(ext_set_i),
        .fsr2_base_i(fsr2_base_i),
        .hit_o(hit_s),
        .dest_file_o(dest_s),
        .indexed_o(idx_s),
        .addr_o(addr_s)
    );

    // =========================================================================
    // Phase sequencing, execution and flush counting.
    // =========================================================================
    always_comb begin
        phase_d = phase_q;
        flush_d = flush_q;
        act_d = act_q;
        dest_d = dest_q;
        idx_d = idx_q;
        addr_d = addr_q;
        rd_d = rd_q;
        res_d = res_q;
        nw_d = nw_q;
        file_d = '0;
        wreg_d = '0;
        case (phase_q)
            DSZ_Q4: begin
                phase_d = DSZ_Q1;
                act_d = 1'b0;
                if (flush_q != 2'h0) begin
                    flush_d = flush_q - 2'h1;
                end else if (act_q && res_q == DSZ_ZERO) begin
                    flush_d = (nw_q == 2'h0) ? 2'h1 : nw_q;
                end
            end
            DSZ_Q1: begin
                phase_d = DSZ_Q2;
                if (flush_q == 2'h0 && hit_s) begin
                    act_d = 1'b1;
                    dest_d = dest_s;
                    idx_d = idx_s;
                    addr_d = addr_s;
                    nw_d = (next_words_i > DSZ_MAX_FLUSH) ? DSZ_MAX_FLUSH : next_words_i;
                    file_d.addr = addr_s;
                    file_d.indexed = idx_s;
                    file_d.rd = 1'b1; // Read presented for phase two.
                end
            end
            DSZ_Q2: begin
                phase_d = DSZ_Q3;
                if (act_q) begin
                    rd_d = file_rdata_i;
                end
            end
            DSZ_Q3: begin
                phase_d = DSZ_Q4;
                if (act_q) begin
                    res_d = rd_q - DSZ_ONE;
                    if (dest_q) begin
                        file_d.addr = addr_q;
                        file_d.indexed = idx_q;
                        file_d.wdata = rd_q - DSZ_ONE;
                        file_d.wr = 1'b1;
                    end else begin
                        wreg_d.data = rd_q - DSZ_ONE;
                        wreg_d.wr = 1'b1;
                    end
                end
            end
            default: begin
                phase_d = DSZ_Q1;
            end
        endcase
    end

    // Registers; no status flags are produced here.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= DSZ_Q1;
            flush_q <= 2'h0;
            act_q <= 1'b0;
            dest_q <= 1'b0;
            idx_q <= 1'b0;
            addr_q <= 12'h000;
            rd_q <= 8'h00;
            res_q <= 8'h01;
            nw_q <= 2'h0;
            file_q <= '0;
            wreg_q <= '0;
        end else begin
            phase_q <= phase_d;
            flush_q <= flush_d;
            act_q <= act_d;
            dest_q <= dest_d;
            idx_q <= idx_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            res_q <= res_d;
            nw_q <= nw_d;
            file_q <= file_d;
            wreg_q <= wreg_d;
        end
    end

    // Outputs.
    assign phase_o = phase_q;
    assign file_o = file_q;
    assign wreg_o = wreg_q;
    assign flush_o = (flush_q != 2'h0);
    assign busy_o = act_q || flush_o;
    assign fetch_adv_o = (phase_q == DSZ_Q4);

    // =========================================================================
    // Assertions.
    // =========================================================================
    flush_no_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
        flush_o |-> !file_o.rd && !file_o.wr && !wreg_o.wr)
        else $error("Access during flushed cycle.");

    zero_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q4 && act_q && flush_q == 2'h0 && res_q == DSZ_ZERO)
        |=> flush_o [*4])
        else $error("Zero result did not flush next cycle.");

    nonzero_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q4 && act_q && flush_q == 2'h0 && res_q != DSZ_ZERO)
        |=> !flush_o)
        else $error("Nonzero result flushed.");

    two_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q4 && act_q && flush_q == 2'h0 && res_q == DSZ_ZERO && nw_q == 2'h2)
        |=> flush_o [*8])
        else $error("Two-word skip lacks two flush cycles.");

    dest_w_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q3 && act_q && !dest_q) |=> wreg_o.wr && !file_o.wr
            && wreg_o.data == $past(rd_q) - DSZ_ONE)
        else $error("Working register not written.");

    dest_f_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q3 && act_q && dest_q) |=> file_o.wr && !wreg_o.wr
            && file_o.addr == $past(addr_q))
        else $error("File register not written.");

    read_q2_a: assert property (@(posedge clk_i) disable iff (rst_i)
        file_o.rd |-> phase_q == DSZ_Q2)
        else $error("Read outside phase two.");

    opcode_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q1 && !flush_o && opcode_i[DSZ_OPC_HI:DSZ_OPC_LO] == DSZ_OPC)
        |=> act_q)
        else $error("Opcode not taken.");

    bank_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q1 && !flush_o && hit_s && opcode_i[DSZ_BANK_BIT])
        |=> file_o.addr[11:8] == $past(bank_ptr_i))
        else $error("Bank pointer not used.");

    index_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q == DSZ_Q1 && !flush_o && hit_s && !opcode_i[DSZ_BANK_BIT] && ext_set_i
            && opcode_i[7:0] <= DSZ_IDX_MAX) |=> file_o.indexed)
        else $error("Indexed mode not used.");
endmodule : dsz_exec
`default_nettype wire

// ---- dsz_exec_test.sv ----
// Self-checking testbench for the decrement-skip-on-zero executor.
`timescale 1ns/10ps
`default_nettype none
module decrement_skip_if_zero_exec_test;
    import dsz_pkg::*;
    logic clk_i;
    logic rst_i = 1'b1;
    logic [15:0] opcode_i = 16'h0000;
    logic [1:0] next_words_i = 2'h1;
    logic [3:0] bank_ptr_i = 4'h0;
    logic ext_set_i = 1'b0;
    logic [7:0] fsr2_base_i = 8'h00;
    logic [7:0] file_rdata_i = 8'h00;
    dsz_phase_t phase_o;
    dsz_file_req_t file_o;
    dsz_wreg_t wreg_o;
    logic busy_o, flush_o, fetch_adv_o;
    int num_errors = 0;
    int compares = 0;

    // =========================================================================
    // Device under test
    // =========================================================================
    dsz_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .opcode_i(opcode_i),
        .next_words_i(next_words_i), .bank_ptr_i(bank_ptr_i), .ext_set_i(ext_set_i),
        .fsr2_base_i(fsr2_base_i), .file_rdata_i(file_rdata_i), .phase_o(phase_o),
        .file_o(file_o), .wreg_o(wreg_o), .busy_o(busy_o), .flush_o(flush_o),
        .fetch_adv_o(fetch_adv_o));

    // Free-running 50 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // =========================================================================
    // Shared tasks
    // =========================================================================
    // Compares one observed value with its expectation and counts the outcome.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Runs one instruction cycle, entered at the edge that starts a Q1, plus any flush.
    task automatic run_op(input logic [15:0] opc, input logic [1:0] nw, input logic [3:0] bp,
            input logic ext, input logic [7:0] base, input logic [7:0] rdat);
        logic hit;
        logic [7:0] f;
        logic [7:0] res;
        logic [11:0] addr;
        logic idx;
        int nfl;
        hit = (opc[15:10] == 6'b001011);
        f = opc[7:0];
        res = rdat - 8'h01;
        idx = 1'b0;
        if (opc[8]) addr = {bp, f};
        else if (ext && f <= 8'h5f) begin
            addr = {4'h0, 8'(base + f)};
            idx = 1'b1;
        end
        else if (f < 8'h60) addr = {4'h0, f};
        else addr = {4'hf, f};
        nfl = (hit && res == 8'h00) ? ((nw == 2'h0) ? 1 : int'(nw)) : 0;
        opcode_i <= opc;
        next_words_i <= nw;
        bank_ptr_i <= bp;
        ext_set_i <= ext;
        fsr2_base_i <= base;
        file_rdata_i <= rdat;
        @(posedge clk_i);
        #1;
        chk("phase q2", phase_o, DSZ_Q2);
        chk("flush off", flush_o, 1'b0);
        chk("read strobe", file_o.rd, hit);
        chk("early write", file_o.wr | wreg_o.wr, 1'b0);
        chk("busy q2", busy_o, hit);
        chk("advance q2", fetch_adv_o, 1'b0);
        if (hit) chk("address", file_o.addr, addr);
        if (hit) chk("indexed", file_o.indexed, idx);
        repeat (2) @(posedge clk_i);
        #1;
        chk("phase q4", phase_o, DSZ_Q4);
        chk("file write", file_o.wr, hit & opc[9]);
        chk("wreg write", wreg_o.wr, hit & ~opc[9]);
        if (hit && opc[9]) chk("file data", file_o.wdata, res);
        if (hit && !opc[9]) chk("wreg data", wreg_o.data, res);
        chk("busy", busy_o, hit);
        chk("advance", fetch_adv_o, 1'b1);
        @(posedge clk_i);
        if (nfl > 0) begin
            // A matching word arrives while flushing and must be ignored.
            opcode_i <= 16'h2e55;
            file_rdata_i <= 8'h01;
            repeat (4 * nfl) begin
                #1;
                chk("flush", flush_o & busy_o, 1'b1);
                chk("flush access", file_o.rd | file_o.wr | wreg_o.wr, 1'b0);
                @(posedge clk_i);
            end
        end
    endtask : run_op

    // =========================================================================
    // Scenarios
    // =========================================================================
    // Result goes to the file with a bank pointer, then to the working register.
    task automatic t_dest();
        run_op(16'h2f22, 2'h1, 4'h3, 1'b0, 8'h00, 8'h05);
        run_op(16'h2c22, 2'h1, 4'h3, 1'b0, 8'h00, 8'h80);
        $display("test destination done");
    endtask : t_dest

    // Zero results flush one, two, three words; a word count of zero flushes one.
    task automatic t_skip();
        run_op(16'h2c10, 2'h1, 4'h0, 1'b0, 8'h00, 8'h01);
        run_op(16'h2e80, 2'h2, 4'h0, 1'b0, 8'h00, 8'h01);
        run_op(16'h2c60, 2'h3, 4'h5, 1'b1, 8'h30, 8'h01);
        run_op(16'h2d44, 2'h0, 4'h7, 1'b1, 8'h30, 8'h01);
        $display("test skip done");
    endtask : t_skip

    // Indexed offsets at the top boundary and with a high base and zero offset.
    task automatic t_index();
        run_op(16'h2e5f, 2'h1, 4'h2, 1'b1, 8'h30, 8'h00);
        run_op(16'h2c00, 2'h1, 4'h2, 1'b1, 8'hf0, 8'h02);
        $display("test indexed done");
    endtask : t_index

    // A reset in mid-flush clears the skip and leaves the core idle in phase one.
    task automatic t_reset();
        opcode_i <= 16'h2c10;
        next_words_i <= 2'h3;
        file_rdata_i <= 8'h01;
        repeat (5) @(posedge clk_i);
        #1;
        chk("flush before reset", flush_o, 1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        opcode_i <= 16'h0000;
        @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("phase after reset", phase_o, DSZ_Q1);
        chk("idle after reset", flush_o | busy_o, 1'b0);
        repeat (4) @(posedge clk_i);
        $display("test mid-run reset done");
    endtask : t_reset

    // Neighbouring opcodes must not be executed.
    task automatic t_other();
        run_op(16'h2a10, 2'h1, 4'h0, 1'b0, 8'h00, 8'h01);
        run_op(16'h4c10, 2'h1, 4'h0, 1'b0, 8'h00, 8'h01);
        run_op(16'h0f10, 2'h1, 4'h0, 1'b0, 8'h00, 8'h02);
        $display("test other opcodes done");
    endtask : t_other

    // Main sequence: reset, then every scenario back to back.
    initial begin
        repeat (7) @(posedge clk_i);
        #1;
        chk("reset phase", phase_o, DSZ_Q1);
        chk("reset file", file_o, 32'h0);
        chk("reset wreg", wreg_o, 32'h0);
        chk("reset flush", flush_o | busy_o, 1'b0);
        chk("reset advance", fetch_adv_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_dest();
        t_skip();
        t_reset();
        t_index();
        t_other();
        wrap_up();
    end

    // Watchdog: the run needs well under 400 cycles.
    initial begin
        #8000;
        num_errors++;
        wrap_up();
    end
endmodule : decrement_skip_if_zero_exec_test
`default_nettype wire
